// file: design/iops_top.sv
`timescale 1ns/10ps
module iops_top #(
    parameter int PORT_W = 8,
    parameter bit PINS20 = 1'b0
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    input wire logic [7:0] pc_in,
    output logic [7:0] pc_out,
    output logic [7:0] pc_oe,
    input wire logic serial_receive_or_data_drive,
    input wire logic serial_receive_or_data_out,
    output logic serial_receive_or_data_in,
    input wire logic serial_transmit_or_clock_drive,
    input wire logic serial_transmit_or_clock_out,
    output logic serial_transmit_or_clock_in,
    input wire logic serial_data_out_drive,
    input wire logic serial_data_out,
    output logic slave_select_in,
    output logic timer_gate_input
);
    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (PORT_W != 8) begin : g_bad_width
        $error("port width must be eight");
    end

    typedef struct packed {
        logic [7:0] steer;
        logic [7:0] rdata;
    } iops_top_st_t;

    iops_top_st_t st;
    iops_top_st_t next_st;
    logic [7:0] wr_mask;
    logic [7:0] rd_mux;
    logic [2:0][7:0] pin_in_all;
    logic [2:0][7:0] dig_all;
    logic [2:0][7:0] lat_all;
    logic [2:0][7:0] dir_all;
    logic [2:0][7:0] ans_all;
    logic [2:0][7:0] out_all;
    logic [2:0][7:0] oe_all;
    logic [23:0] ovr_en;
    logic [23:0] ovr_val;

    iops_port_if pif [iops_pkg::NUM_PORTS] ();

    assign pin_in_all = {pc_in, pb_in, pa_in};
    assign wr_mask = PINS20 ? iops_pkg::MASK_20 : iops_pkg::MASK_14;

    // ----------------------------------------------------------------
    // per-port strobes and pin wiring
    // ----------------------------------------------------------------
    for (genvar g = 0; g < iops_pkg::NUM_PORTS; g++) begin : g_port
        assign pif[g].wdata = reg_wdata;
        assign pif[g].we_dir = reg_we && reg_addr == iops_pkg::ADDR_DIR_A + 4'(g);
        assign pif[g].we_lat = reg_we && (reg_addr == iops_pkg::ADDR_LAT_A + 4'(g)
            || reg_addr == iops_pkg::ADDR_PIN_A + 4'(g));
        assign pif[g].we_ans = reg_we && reg_addr == iops_pkg::ADDR_ANS_A + 4'(g);
        assign pif[g].pin_in = pin_in_all[g];
        assign pif[g].ovr_en = ovr_en[g*8 +: 8];
        assign pif[g].ovr_val = ovr_val[g*8 +: 8];
        assign dig_all[g] = pif[g].dig_in;
        assign lat_all[g] = pif[g].lat;
        assign dir_all[g] = pif[g].dir;
        assign ans_all[g] = pif[g].ans;
        assign out_all[g] = pif[g].pin_out;
        assign oe_all[g] = pif[g].pin_oe;

        iops_port u_port (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .pif(pif[g])
        );
    end

    assign pa_out = out_all[0];
    assign pb_out = out_all[1];
    assign pc_out = out_all[2];
    assign pa_oe = oe_all[0];
    assign pb_oe = oe_all[1];
    assign pc_oe = oe_all[2];

    // ----------------------------------------------------------------
    // steering of peripheral functions
    // ----------------------------------------------------------------
    iops_steer_map u_map (
        .sel(st.steer),
        .pins20(PINS20),
        .rx_drive(serial_receive_or_data_drive),
        .rx_out(serial_receive_or_data_out),
        .tx_drive(serial_transmit_or_clock_drive),
        .tx_out(serial_transmit_or_clock_out),
        .sdo_drive(serial_data_out_drive),
        .sdo_out(serial_data_out),
        .dig_in(dig_all),
        .ovr_en(ovr_en),
        .ovr_val(ovr_val),
        .rx_in(serial_receive_or_data_in),
        .tx_in(serial_transmit_or_clock_in),
        .ss_in(slave_select_in),
        .tg_in(timer_gate_input)
    );

    // ----------------------------------------------------------------
    // read select
    // ----------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            iops_pkg::ADDR_PIN_A: rd_mux = dig_all[0];
            iops_pkg::ADDR_PIN_A + 4'h1: rd_mux = dig_all[1];
            iops_pkg::ADDR_PIN_A + 4'h2: rd_mux = dig_all[2];
            iops_pkg::ADDR_DIR_A: rd_mux = dir_all[0];
            iops_pkg::ADDR_DIR_A + 4'h1: rd_mux = dir_all[1];
            iops_pkg::ADDR_DIR_A + 4'h2: rd_mux = dir_all[2];
            iops_pkg::ADDR_LAT_A: rd_mux = lat_all[0];
            iops_pkg::ADDR_LAT_A + 4'h1: rd_mux = lat_all[1];
            iops_pkg::ADDR_LAT_A + 4'h2: rd_mux = lat_all[2];
            iops_pkg::ADDR_ANS_A: rd_mux = ans_all[0];
            iops_pkg::ADDR_ANS_A + 4'h1: rd_mux = ans_all[1];
            iops_pkg::ADDR_ANS_A + 4'h2: rd_mux = ans_all[2];
            iops_pkg::ADDR_ALT_SEL0: rd_mux = st.steer;
            default: rd_mux = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // steering register and read data
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;
        if (reg_we && reg_addr == iops_pkg::ADDR_ALT_SEL0) begin
            next_st.steer = reg_wdata & wr_mask;
        end
        if (reg_re) begin
            next_st.rdata = rd_mux;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st <= '{steer: iops_pkg::STEER_RST, rdata: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_LAT_READ: assert property (reg_re && reg_addr == iops_pkg::ADDR_LAT_A
        |=> reg_rdata == $past(lat_all[0]))
        else $error("latch read wrong");
    AST_PIN_READ: assert property (reg_re && reg_addr == iops_pkg::ADDR_PIN_A + 4'h2
        |=> reg_rdata == $past(pc_in & ans_all[2] ^ pc_in))
        else $error("pin level read wrong");
    AST_PIN_WR_LAT: assert property (reg_we && reg_addr == iops_pkg::ADDR_PIN_A + 4'h1
        |=> lat_all[1] == $past(reg_wdata))
        else $error("pin write missed latch");
    AST_RSV_ZERO: assert property ((st.steer & ~wr_mask) == 8'h00)
        else $error("reserved steering bit set");
    AST_STEER_WR: assert property (reg_we && reg_addr == iops_pkg::ADDR_ALT_SEL0
        |=> st.steer == ($past(reg_wdata) & wr_mask))
        else $error("steering write lost");
    AST_DIR_KEEP: assert property (reg_we && reg_addr == iops_pkg::ADDR_ALT_SEL0
        |=> dir_all == $past(dir_all))
        else $error("direction changed by steering");
    AST_RX_A1: assert property (!PINS20 && st.steer[iops_pkg::SEL_RX]
        && serial_receive_or_data_drive |-> pa_oe[1] && pa_out[1] == serial_receive_or_data_out)
        else $error("receive not on a1");
    AST_TX_ROUTE: assert property (serial_transmit_or_clock_drive && !st.steer[iops_pkg::SEL_TX]
        |-> (PINS20 ? pb_oe[7] : pc_oe[4]))
        else $error("transmit not on default pin");
    AST_SDO_UNSEL: assert property (!PINS20 && !st.steer[iops_pkg::SEL_SDO]
        |-> pa_oe[4] == !dir_all[0][4] && pa_out[4] == lat_all[0][4])
        else $error("unselected pin overridden");
    AST_TG_A4: assert property (!st.steer[iops_pkg::SEL_TG] |-> timer_gate_input == dig_all[0][4])
        else $error("timer gate not from a4");

    COV_RX_ALT: cover property (st.steer[iops_pkg::SEL_RX] && serial_receive_or_data_drive);
    COV_PIN_WRITE: cover property (reg_we && reg_addr == iops_pkg::ADDR_PIN_A ##1 reg_re);
    COV_STEER_RB: cover property (reg_we && reg_addr == iops_pkg::ADDR_ALT_SEL0
        ##1 reg_re && reg_addr == iops_pkg::ADDR_ALT_SEL0);
endmodule // iops_top

// file: design/iops_pkg.sv
package iops_pkg;
    // ----------------------------------------------------------------
    // register map, word index on the plain register port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_PIN_A = 4'h0; // pin level, ports a/b/c follow
    localparam logic [3:0] ADDR_DIR_A = 4'h3; // direction, ports a/b/c follow
    localparam logic [3:0] ADDR_LAT_A = 4'h6; // output latch, ports a/b/c follow
    localparam logic [3:0] ADDR_ANS_A = 4'h9; // analog select, ports a/b/c follow
    localparam logic [3:0] ADDR_ALT_SEL0 = 4'hC;
    localparam int NUM_PORTS = 3;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] DIR_RST = 8'hFF; // all pins input
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [7:0] ANS_RST = 8'hFF; // digital input off
    localparam logic [7:0] STEER_RST = 8'h00;

    // ----------------------------------------------------------------
    // steering field positions and writable masks
    // ----------------------------------------------------------------
    localparam int SEL_RX = 7;
    localparam int SEL_SDO = 6;
    localparam int SEL_SS = 5;
    localparam int SEL_TG = 3;
    localparam int SEL_TX = 2;
    localparam logic [7:0] MASK_14 = 8'hEC;
    localparam logic [7:0] MASK_20 = 8'h8C;

    // ----------------------------------------------------------------
    // pin codes: port index in [4:3], bit in [2:0]
    // ----------------------------------------------------------------
    localparam logic [4:0] RX14_0 = 5'h15; // c5
    localparam logic [4:0] RX14_1 = 5'h01; // a1
    localparam logic [4:0] RX20_0 = 5'h0D; // b5
    localparam logic [4:0] RX20_1 = 5'h15; // c5
    localparam logic [4:0] SDO14_0 = 5'h12; // c2
    localparam logic [4:0] SDO14_1 = 5'h04; // a4
    localparam logic [4:0] SDO20 = 5'h17; // c7
    localparam logic [4:0] SS14_0 = 5'h13; // c3
    localparam logic [4:0] SS14_1 = 5'h03; // a3
    localparam logic [4:0] SS20 = 5'h16; // c6
    localparam logic [4:0] TG_0 = 5'h04; // a4
    localparam logic [4:0] TG_1 = 5'h03; // a3
    localparam logic [4:0] TX14_0 = 5'h14; // c4
    localparam logic [4:0] TX14_1 = 5'h00; // a0
    localparam logic [4:0] TX20_0 = 5'h0F; // b7
    localparam logic [4:0] TX20_1 = 5'h14; // c4
endpackage

// file: design/iops_port_if.sv
`timescale 1ns/10ps
// one port's register strobes, state and pin paths
interface iops_port_if;
    logic we_dir;
    logic we_lat;
    logic we_ans;
    logic [7:0] wdata;
    logic [7:0] dir;
    logic [7:0] lat;
    logic [7:0] ans;
    logic [7:0] dig_in;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] ovr_en;
    logic [7:0] ovr_val;
    modport port (input we_dir, we_lat, we_ans, wdata, pin_in, ovr_en, ovr_val,
        output dir, lat, ans, dig_in, pin_out, pin_oe);
    modport ctrl (output we_dir, we_lat, we_ans, wdata, pin_in, ovr_en, ovr_val,
        input dir, lat, ans, dig_in, pin_out, pin_oe);
endinterface

// file: design/iops_port.sv
`timescale 1ns/10ps
module iops_port (
    input wire logic clk_sys,
    input wire logic resetn,
    iops_port_if.port pif
);
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] lat;
        logic [7:0] ans;
    } iops_port_st_t;

    iops_port_st_t st;
    iops_port_st_t next_st;

    // ----------------------------------------------------------------
    // register updates
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (pif.we_dir) begin
            next_st.dir = pif.wdata;
        end
        if (pif.we_lat) begin
            next_st.lat = pif.wdata;
        end
        if (pif.we_ans) begin
            next_st.ans = pif.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st <= '{dir: iops_pkg::DIR_RST, lat: iops_pkg::LAT_RST, ans: iops_pkg::ANS_RST};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // pin drive and input paths
    // ----------------------------------------------------------------
    assign pif.dir = st.dir;
    assign pif.lat = st.lat;
    assign pif.ans = st.ans;
    assign pif.pin_oe = pif.ovr_en | ~st.dir;
    assign pif.pin_out = (pif.ovr_en & pif.ovr_val) | (~pif.ovr_en & st.lat);
    assign pif.dig_in = pif.pin_in & ~st.ans;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_ANALOG_BLOCKS: assert property ((pif.dig_in & st.ans) == 8'h00)
        else $error("analog pin seen on digital input");
    AST_DIR_DRIVES: assert property (((pif.pin_oe ^ ~st.dir) & ~pif.ovr_en) == 8'h00)
        else $error("direction not obeyed");
    AST_OVR_TAKES: assert property ((pif.ovr_en & ~pif.pin_oe) == 8'h00)
        else $error("peripheral override not driving");
    AST_LAT_WRITE: assert property (pif.we_lat |=> pif.pin_out == ($past(pif.wdata) & ~pif.ovr_en
        | pif.ovr_val & pif.ovr_en))
        else $error("latch write not driven");
endmodule // iops_port

// file: design/iops_steer_map.sv
`timescale 1ns/10ps
module iops_steer_map (
    input wire logic [7:0] sel,
    input wire logic pins20,
    input wire logic rx_drive,
    input wire logic rx_out,
    input wire logic tx_drive,
    input wire logic tx_out,
    input wire logic sdo_drive,
    input wire logic sdo_out,
    input wire logic [23:0] dig_in,
    output logic [23:0] ovr_en,
    output logic [23:0] ovr_val,
    output logic rx_in,
    output logic tx_in,
    output logic ss_in,
    output logic tg_in
);
    logic [4:0] rx_pin;
    logic [4:0] tx_pin;
    logic [4:0] sdo_pin;
    logic [4:0] ss_pin;
    logic [4:0] tg_pin;

    // ----------------------------------------------------------------
    // selected pin per function
    // ----------------------------------------------------------------
    always_comb begin
        if (pins20) begin
            rx_pin = sel[iops_pkg::SEL_RX] ? iops_pkg::RX20_1 : iops_pkg::RX20_0;
            tx_pin = sel[iops_pkg::SEL_TX] ? iops_pkg::TX20_1 : iops_pkg::TX20_0;
            sdo_pin = iops_pkg::SDO20;
            ss_pin = iops_pkg::SS20;
        end else begin
            rx_pin = sel[iops_pkg::SEL_RX] ? iops_pkg::RX14_1 : iops_pkg::RX14_0;
            tx_pin = sel[iops_pkg::SEL_TX] ? iops_pkg::TX14_1 : iops_pkg::TX14_0;
            sdo_pin = sel[iops_pkg::SEL_SDO] ? iops_pkg::SDO14_1 : iops_pkg::SDO14_0;
            ss_pin = sel[iops_pkg::SEL_SS] ? iops_pkg::SS14_1 : iops_pkg::SS14_0;
        end
        tg_pin = sel[iops_pkg::SEL_TG] ? iops_pkg::TG_1 : iops_pkg::TG_0;
    end

    // ----------------------------------------------------------------
    // overrides land only on the selected pin
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 24; i++) begin : g_pin
        localparam logic [4:0] CODE = 5'(i);
        logic hit_rx;
        logic hit_tx;
        logic hit_sdo;
        assign hit_rx = rx_drive && rx_pin == CODE;
        assign hit_tx = tx_drive && tx_pin == CODE;
        assign hit_sdo = sdo_drive && sdo_pin == CODE;
        assign ovr_en[i] = hit_rx | hit_tx | hit_sdo;
        assign ovr_val[i] = hit_tx ? tx_out : (hit_rx ? rx_out : sdo_out);
    end

    // inputs taken from the selected pin
    assign rx_in = dig_in[rx_pin];
    assign tx_in = dig_in[tx_pin];
    assign ss_in = dig_in[ss_pin];
    assign tg_in = dig_in[tg_pin];
endmodule // iops_steer_map

// file: bench/iops_pin_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// pin model: board wiring seen from the port pins
// ----------------------------------------------------------------
module iops_pin_model (
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe,
    input wire logic [23:0] ext_level,
    output logic [23:0] pin_in
);
    // a driven pin shows the port value, an undriven one the outside driver
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // iops_pin_model

// file: bench/io_port_alt_pin_steering_tb.sv
`timescale 1ns/10ps
module io_port_alt_pin_steering_tb;
    // ----------------------------------------------------------------
    // stimulus, outputs and bench model
    // ----------------------------------------------------------------
    localparam int LIMIT = 10000;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [2:0] drv = 3'h0; // sdo, tx, rx drive
    logic [2:0] dv = 3'h0; // sdo, tx, rx value
    logic [23:0] ext = 24'h00_0000;
    wire [1:0][7:0] rdata;
    wire [1:0][23:0] oe_w;
    wire [1:0][23:0] out_w;
    wire [1:0][23:0] in_w;
    wire [1:0][3:0] fn_w; // gate, slave select, tx, rx
    logic [23:0] m_dir = 24'hff_ffff;
    logic [23:0] m_lat = 24'h00_0000;
    logic [23:0] m_ans = 24'hff_ffff;
    logic [7:0] m_sel = 8'h00;
    int seed = 58985;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;

    // clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    // 14-pin and 20-pin mappings side by side on one register bus
    for (genvar k = 0; k < 2; k++) begin : g_dev
        iops_top #(.PORT_W(8), .PINS20(k == 1)) dut_u (
            .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
            .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(rdata[k]),
            .pa_in(in_w[k][7:0]), .pa_out(out_w[k][7:0]), .pa_oe(oe_w[k][7:0]),
            .pb_in(in_w[k][15:8]), .pb_out(out_w[k][15:8]), .pb_oe(oe_w[k][15:8]),
            .pc_in(in_w[k][23:16]), .pc_out(out_w[k][23:16]), .pc_oe(oe_w[k][23:16]),
            .serial_receive_or_data_drive(drv[0]), .serial_receive_or_data_out(dv[0]),
            .serial_receive_or_data_in(fn_w[k][0]),
            .serial_transmit_or_clock_drive(drv[1]), .serial_transmit_or_clock_out(dv[1]),
            .serial_transmit_or_clock_in(fn_w[k][1]),
            .serial_data_out_drive(drv[2]), .serial_data_out(dv[2]),
            .slave_select_in(fn_w[k][2]), .timer_gate_input(fn_w[k][3])
        );
        iops_pin_model pins_u (.pin_out(out_w[k]), .pin_oe(oe_w[k]), .ext_level(ext), .pin_in(in_w[k]));
    end

    // ----------------------------------------------------------------
    // expectations
    // ----------------------------------------------------------------
    // pin index of function fn: 0 rx, 1 tx, 2 sdo, 3 slave select, 4 gate
    function automatic int f_pin(input int k, input int fn);
        case (fn)
            0: return (k == 1) ? (m_sel[7] ? 21 : 13) : (m_sel[7] ? 1 : 21);
            1: return (k == 1) ? (m_sel[2] ? 20 : 15) : (m_sel[2] ? 0 : 20);
            2: return (k == 1) ? 23 : (m_sel[6] ? 4 : 18);
            3: return (k == 1) ? 22 : (m_sel[5] ? 3 : 19);
            default: return m_sel[3] ? 3 : 4;
        endcase
    endfunction

    // override enable and value, packed as {enable, value}
    function automatic logic [47:0] f_ovr(input int k);
        logic [23:0] en;
        logic [23:0] val;
        en = '0;
        val = '0;
        for (int fn = 0; fn < 3; fn++) begin
            en[f_pin(k, fn)] = drv[fn];
            val[f_pin(k, fn)] = dv[fn];
        end
        return {en, val};
    endfunction

    function automatic logic [23:0] f_oe(input int k);
        logic [47:0] o;
        o = f_ovr(k);
        return ~m_dir | o[47:24];
    endfunction

    function automatic logic [23:0] f_out(input int k);
        logic [47:0] o;
        o = f_ovr(k);
        return (o[47:24] & o[23:0]) | (~o[47:24] & m_lat);
    endfunction

    // digital level seen inside, zero where analog is selected
    function automatic logic [23:0] f_dig(input int k);
        return ((f_oe(k) & f_out(k)) | (~f_oe(k) & ext)) & ~m_ans;
    endfunction

    function automatic logic [3:0] f_fn(input int k);
        logic [3:0] r;
        logic [23:0] dg;
        dg = f_dig(k);
        for (int i = 0; i < 4; i++) begin
            r[i] = dg[f_pin(k, (i < 2) ? i : i + 1)];
        end
        return r;
    endfunction

    function automatic logic [7:0] f_reg(input int k, input int a);
        logic [23:0] dg;
        dg = f_dig(k);
        if (a < 3) return dg[a*8 +: 8];
        if (a < 6) return m_dir[(a-3)*8 +: 8];
        if (a < 9) return m_lat[(a-6)*8 +: 8];
        if (a < 12) return m_ans[(a-9)*8 +: 8];
        if (a == 12) return m_sel & ((k == 1) ? 8'h8c : 8'hec);
        return 8'h00;
    endfunction

    // ----------------------------------------------------------------
    // bus cycles and compares
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write cycle, then the bench model follows
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int p;
        p = int'(a) % 3;
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk_sys);
        reg_we <= 1'b0;
        if (a < 3 || (a >= 6 && a < 9)) m_lat[p*8 +: 8] = d;
        else if (a < 6) m_dir[p*8 +: 8] = d;
        else if (a < 12) m_ans[p*8 +: 8] = d;
        else if (a == 12) m_sel = d;
    endtask

    // one read cycle, data checked in the following cycle
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        @(negedge clk_sys);
        for (int k = 0; k < 2; k++) begin
            chk("register", {16'h0, f_reg(k, a)}, {16'h0, rdata[k]});
        end
        @(posedge clk_sys);
    endtask

    task automatic rd_all();
        for (int a = 0; a < 16; a++) begin
            rd(4'(a));
        end
    endtask

    task automatic chk_pins();
        @(negedge clk_sys);
        for (int k = 0; k < 2; k++) begin
            chk("pin enable", f_oe(k), oe_w[k]);
            chk("pin drive", f_out(k), out_w[k]);
            chk("function input", {20'h0, f_fn(k)}, {20'h0, fn_w[k]});
        end
        @(posedge clk_sys);
    endtask

    task automatic mreset();
        m_dir = 24'hff_ffff;
        m_lat = 24'h00_0000;
        m_ans = 24'hff_ffff;
        m_sel = 8'h00;
    endtask

    task automatic test_done();
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [31:0] d;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        chk_pins();
        rd_all();
        wr(4'hc, 8'hff);
        rd(4'hc);
        @(posedge clk_sys);
        wr(4'hd, 8'h5a);
        rd(4'hd);
        // random traffic with peripheral drives and outside levels moving
        repeat (300) begin
            r = $random(seed);
            d = $random(seed);
            drv <= r[2:0];
            dv <= r[5:3];
            ext <= d[23:0];
            @(posedge clk_sys);
            wr(r[11:8], r[19:12]);
            rd(r[11:8]);
            chk_pins();
        end
        // second reset in mid-run
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        mreset();
        resetn <= 1'b1;
        @(posedge clk_sys);
        rd_all();
        chk_pins();
        test_done();
    end

    // cut a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            errors++;
            test_done();
        end
    end
endmodule // io_port_alt_pin_steering_tb
